// ### mjid_defs.svh
// constants for the boundary-scan instruction decode and identification word
// assumes it is included by bare name from the package and the design file
//
// Contract
// - code 00 selects boundary register, captures ring, outputs driven from boundary register values
// - code 21 selects identification register loaded with fixed word
// - code 05 snapshots ring into boundary register and selects it
// - code 07 selects bypass, outputs driven from boundary register values
// - code 03 selects bypass, all outputs forced high impedance
// - code ff selects single-bit bypass, memory unaffected
// - identification bit 0 is constant one
// - fixed eleven-bit maker code in identification bits 11 to 1
// - fixed sixteen-bit device code in identification bits 27 to 12
// - eight-bit instruction takes effect only at update-IR
// - identification instruction selected at power-up and test-logic-reset
// - boundary 113 cells, bypass one cell, identification 32 cells
`ifndef MJID_DEFS_SVH
`define MJID_DEFS_SVH
`define MJID_IR_W 8
`define MJID_BSR_W 113
`define MJID_ID_W 32
`define MJID_OP_EXTEST 8'h00
`define MJID_OP_IDCODE 8'h21
`define MJID_OP_SAMPLE 8'h05
`define MJID_OP_CLAMP 8'h07
`define MJID_OP_HIGHZ 8'h03
`define MJID_OP_BYPASS 8'hff
`define MJID_IR_CAPTURE 8'h01
`define MJID_ID_PRESENT 1'h1
`define MJID_MAKER_DEF 11'h2aa
`define MJID_DEVICE_DEF 16'h0000
`define MJID_REV_DEF 4'h0
`define MJID_LSB 0
`endif

// ### mjid_pkg.sv
// types for the boundary-scan instruction decode
// assumes mjid_defs.svh is on the include path
`include "mjid_defs.svh"
package mjid_pkg;
	typedef enum logic [3:0] {
		MJID_TLR = 4'h0, MJID_RTI = 4'h1, MJID_SEL_DR = 4'h2, MJID_CAP_DR = 4'h3,
		MJID_SH_DR = 4'h4, MJID_EX1_DR = 4'h5, MJID_PAU_DR = 4'h6, MJID_EX2_DR = 4'h7,
		MJID_UPD_DR = 4'h8, MJID_SEL_IR = 4'h9, MJID_CAP_IR = 4'ha, MJID_SH_IR = 4'hb,
		MJID_EX1_IR = 4'hc, MJID_PAU_IR = 4'hd, MJID_EX2_IR = 4'he, MJID_UPD_IR = 4'hf
	} mjid_state_t;
	typedef enum logic [1:0] {
		MJID_SEL_BSR = 2'h0, MJID_SEL_ID = 2'h1, MJID_SEL_BYP = 2'h2
	} mjid_sel_t;
endpackage

// ### mjid_tap.sv
// test access port with instruction decode, bypass, identification and boundary register
// assumes the test clock is far slower than clk_in and is sampled by it
`timescale 1ns/1ps
`default_nettype none
`include "mjid_defs.svh"
module mjid_tap #(
	parameter logic [10:0] MAKER_CODE = `MJID_MAKER_DEF, // arbitrary value
	parameter logic [15:0] DEVICE_CODE = `MJID_DEVICE_DEF, // arbitrary value
	parameter logic [3:0] REVISION = `MJID_REV_DEF // arbitrary value
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// scan pins
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic tdo_out,
	output logic tdo_oe_out,
	// ring values seen at the balls
	input wire logic [`MJID_BSR_W-1:0] ring_in,
	// ball control toward the output drivers
	output logic [`MJID_BSR_W-1:0] ring_drive_out,
	output logic test_drive_out,
	output logic highz_out,
	// current instruction
	output logic [`MJID_IR_W-1:0] instr_out
);
	import mjid_pkg::*;

	// ************************************************
	// synchronisers and edge detection
	// ************************************************
	logic rst_m_q, rst_s_q;
	logic [2:0] tck_q, tms_q, tdi_q;
	logic [`MJID_BSR_W-1:0] ring_m_q, ring_s_q;
	logic rise, fall;

	// reset release through two flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_q <= rst_m_q;
		end
	end

	// stage 0 is read only by stage 1; stage 2 gives the edge history
	always_ff @(posedge clk_in or negedge rst_s_q) begin
		if (!rst_s_q) begin
			tck_q <= 3'h0;
			tms_q <= 3'h7;
			tdi_q <= 3'h0;
		end else begin
			tck_q <= {tck_q[1:0], tck_in};
			tms_q <= {tms_q[1:0], tms_in};
			tdi_q <= {tdi_q[1:0], tdi_in};
		end
	end

	// ball values come from the memory clock domain, so they pass two flops before capture
	always_ff @(posedge clk_in or negedge rst_s_q) begin
		if (!rst_s_q) begin
			ring_m_q <= '0;
			ring_s_q <= '0;
		end else begin
			ring_m_q <= ring_in;
			ring_s_q <= ring_m_q;
		end
	end
	assign rise = tck_q[1] & ~tck_q[2];
	assign fall = ~tck_q[1] & tck_q[2];

	// ************************************************
	// controller
	// ************************************************
	mjid_state_t st_q, st_d;
	logic tms;
	assign tms = tms_q[1];

	// next state of the sixteen-state controller
	always_comb begin
		case (st_q)
			MJID_TLR: st_d = tms ? MJID_TLR : MJID_RTI;
			MJID_RTI: st_d = tms ? MJID_SEL_DR : MJID_RTI;
			MJID_SEL_DR: st_d = tms ? MJID_SEL_IR : MJID_CAP_DR;
			MJID_CAP_DR: st_d = tms ? MJID_EX1_DR : MJID_SH_DR;
			MJID_SH_DR: st_d = tms ? MJID_EX1_DR : MJID_SH_DR;
			MJID_EX1_DR: st_d = tms ? MJID_UPD_DR : MJID_PAU_DR;
			MJID_PAU_DR: st_d = tms ? MJID_EX2_DR : MJID_PAU_DR;
			MJID_EX2_DR: st_d = tms ? MJID_UPD_DR : MJID_SH_DR;
			MJID_UPD_DR: st_d = tms ? MJID_SEL_DR : MJID_RTI;
			MJID_SEL_IR: st_d = tms ? MJID_TLR : MJID_CAP_IR;
			MJID_CAP_IR: st_d = tms ? MJID_EX1_IR : MJID_SH_IR;
			MJID_SH_IR: st_d = tms ? MJID_EX1_IR : MJID_SH_IR;
			MJID_EX1_IR: st_d = tms ? MJID_UPD_IR : MJID_PAU_IR;
			MJID_PAU_IR: st_d = tms ? MJID_EX2_IR : MJID_PAU_IR;
			MJID_EX2_IR: st_d = tms ? MJID_UPD_IR : MJID_SH_IR;
			MJID_UPD_IR: st_d = tms ? MJID_SEL_DR : MJID_RTI;
			default: st_d = MJID_TLR;
		endcase
	end

	// state advances on rising test clock edges only
	always_ff @(posedge clk_in or negedge rst_s_q) begin
		if (!rst_s_q) begin
			st_q <= MJID_TLR;
		end else if (rise) begin
			st_q <= st_d;
		end
	end

	// ************************************************
	// instruction register
	// ************************************************
	logic [`MJID_IR_W-1:0] ir_sh_q, ir_q;

	// shift stage and update stage are separate so shifting never disturbs the balls
	always_ff @(posedge clk_in or negedge rst_s_q) begin
		if (!rst_s_q) begin
			ir_sh_q <= `MJID_IR_CAPTURE;
			ir_q <= `MJID_OP_IDCODE;
		end else if (rise) begin
			// reload on entry so a test clock parked in reset already shows the id code
			if (st_d == MJID_TLR) begin
				ir_q <= `MJID_OP_IDCODE;
			end
			case (st_q)
				MJID_CAP_IR: ir_sh_q <= `MJID_IR_CAPTURE;
				MJID_SH_IR: ir_sh_q <= {tdi_q[1], ir_sh_q[`MJID_IR_W-1:1]};
				MJID_UPD_IR: ir_q <= ir_sh_q;
				default: ir_sh_q <= ir_sh_q;
			endcase
		end
	end

	// ************************************************
	// decode
	// ************************************************
	mjid_sel_t sel;

	// reserved codes fall to bypass so a stray code cannot lengthen the chain
	function automatic mjid_sel_t mjid_decode(input logic [`MJID_IR_W-1:0] op);
		case (op)
			`MJID_OP_EXTEST: mjid_decode = MJID_SEL_BSR;
			`MJID_OP_SAMPLE: mjid_decode = MJID_SEL_BSR;
			`MJID_OP_IDCODE: mjid_decode = MJID_SEL_ID;
			`MJID_OP_CLAMP: mjid_decode = MJID_SEL_BYP;
			`MJID_OP_HIGHZ: mjid_decode = MJID_SEL_BYP;
			`MJID_OP_BYPASS: mjid_decode = MJID_SEL_BYP;
			default: mjid_decode = MJID_SEL_BYP;
		endcase
	endfunction
	assign sel = mjid_decode(ir_q);

	// ************************************************
	// data registers
	// ************************************************
	logic [`MJID_BSR_W-1:0] bsr_q, bsr_upd_q;
	logic [`MJID_ID_W-1:0] id_q;
	logic byp_q;
	logic [`MJID_ID_W-1:0] id_word;
	assign id_word = {REVISION, DEVICE_CODE, MAKER_CODE, `MJID_ID_PRESENT};

	// capture, shift and update of the selected data register
	always_ff @(posedge clk_in or negedge rst_s_q) begin
		if (!rst_s_q) begin
			bsr_q <= '0;
			bsr_upd_q <= '0;
			id_q <= '0;
			byp_q <= 1'b0;
		end else if (rise) begin
			case (st_q)
				MJID_CAP_DR: begin
					byp_q <= 1'b0;
					id_q <= id_word;
					if (sel == MJID_SEL_BSR) begin
						bsr_q <= ring_s_q;
					end
				end
				MJID_SH_DR: begin
					byp_q <= tdi_q[1];
					if (sel == MJID_SEL_ID) begin
						id_q <= {tdi_q[1], id_q[`MJID_ID_W-1:1]};
					end
					if (sel == MJID_SEL_BSR) begin
						bsr_q <= {tdi_q[1], bsr_q[`MJID_BSR_W-1:1]};
					end
				end
				MJID_UPD_DR: begin
					if (sel == MJID_SEL_BSR) begin
						bsr_upd_q <= bsr_q;
					end
				end
				default: byp_q <= byp_q;
			endcase
		end
	end

	// ************************************************
	// serial output and ball control
	// ************************************************
	// output changes on falling edges, enabled only in shift states
	always_ff @(posedge clk_in or negedge rst_s_q) begin
		if (!rst_s_q) begin
			tdo_out <= 1'b0;
			tdo_oe_out <= 1'b0;
		end else if (fall) begin
			tdo_oe_out <= (st_q == MJID_SH_IR) || (st_q == MJID_SH_DR);
			if (st_q == MJID_SH_IR) begin
				tdo_out <= ir_sh_q[`MJID_LSB];
			end else if (sel == MJID_SEL_BSR) begin
				tdo_out <= bsr_q[`MJID_LSB];
			end else if (sel == MJID_SEL_ID) begin
				tdo_out <= id_q[`MJID_LSB];
			end else begin
				tdo_out <= byp_q;
			end
		end
	end

	// extest and clamp drive balls from the update stage; highz floats them; memory paths stay untouched otherwise
	always_ff @(posedge clk_in or negedge rst_s_q) begin
		if (!rst_s_q) begin
			ring_drive_out <= '0;
			test_drive_out <= 1'b0;
			highz_out <= 1'b0;
			instr_out <= `MJID_OP_IDCODE;
		end else begin
			ring_drive_out <= bsr_upd_q;
			test_drive_out <= (ir_q == `MJID_OP_EXTEST) || (ir_q == `MJID_OP_CLAMP);
			highz_out <= (ir_q == `MJID_OP_HIGHZ);
			instr_out <= ir_q;
		end
	end
endmodule
`default_nettype wire

// ### mjid_tap_props.sv
// checker for the scan port outputs of mjid_tap
// assumes a bind to mjid_tap and sight of its ports only
`timescale 1ns/1ps
`default_nettype none
module mjid_tap_props (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tdo_out,
	input wire logic tdo_oe_out,
	input wire logic [112:0] ring_drive_out,
	input wire logic test_drive_out,
	input wire logic highz_out,
	input wire logic [7:0] instr_out
);
	// ********
	// output relations
	// ********
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_highz_code: assert property (highz_out == (instr_out == 8'h03))
		else $error("float flag disagrees with instruction");
	chk_drive_code: assert property (test_drive_out == (instr_out == 8'h00 || instr_out == 8'h07))
		else $error("drive flag disagrees with instruction");
	chk_instr_hold: assert property ($changed(instr_out) |-> !tdo_oe_out)
		else $error("instruction moved while shifting");
	chk_ring_hold: assert property ($changed(ring_drive_out) |-> !tdo_oe_out)
		else $error("ball values moved while shifting");
	chk_oe_span: assert property ($rose(tdo_oe_out) |=> tdo_oe_out[*4])
		else $error("output enable too short");
	chk_tdo_hold: assert property ($changed(tdo_out) |=> $stable(tdo_out)[*2])
		else $error("serial out glitch");
	chk_reset_id: assert property ($rose(rst_n_in) |-> instr_out == 8'h21 && !tdo_oe_out)
		else $error("bad instruction after reset");
	chk_id_quiet: assert property (instr_out inside {8'h21, 8'hff} |-> !test_drive_out && !highz_out)
		else $error("ball control under a quiet code");
	// main scenarios reached
	cover property ($rose(highz_out));
	cover property ($rose(test_drive_out));
	cover property ($changed(ring_drive_out));
endmodule
`default_nettype wire

// ### mjid_ctl_model.sv
// behavioural scan controller driving the test pins
// assumes callers start a task just after a system clock edge
`timescale 1ns/1ps
`default_nettype none
module mjid_ctl_model (
	// scan pins
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in
);
	// ********
	// pin sequencing
	// ********
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end
	// one test clock; tdo is taken just before the fall since it updates late
	task step(input logic ms, input logic di, output logic dout);
		tms_out = ms;
		tdi_out = di;
		#100 tck_out = 1'b1;
		#90 dout = tdo_in;
		#10 tck_out = 1'b0;
	endtask
	// idle to shift, n bits lsb first, update, back to idle; unused tdi toggles
	task scan(input logic ir, input int n, input logic [112:0] din, output logic [112:0] dout);
		logic x;
		dout = '0;
		step(1'b1, ~tdi_out, x);
		if (ir) step(1'b1, ~tdi_out, x);
		step(1'b0, ~tdi_out, x);
		step(1'b0, ~tdi_out, x);
		for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
		step(1'b1, ~tdi_out, x);
		step(1'b0, ~tdi_out, x);
	endtask
	// five high mode clocks reach test-logic-reset from anywhere
	task tlr();
		logic x;
		for (int i = 0; i < 5; i++) step(1'b1, ~tdi_out, x);
		step(1'b0, ~tdi_out, x);
	endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for mjid_tap with a behavioural scan controller
// assumes mjid_defs.svh on the include path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ********
	// harness
	// ********
	localparam logic [31:0] ID = {4'h5, 16'h1234, 11'h155, 1'b1}; // fields arbitrary
	localparam logic [112:0] RING = 113'h1_0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic tck_in, tms_in, tdi_in, tdo_out, tdo_oe_out, test_drive_out, highz_out;
	logic [112:0] ring_in = RING;
	logic [112:0] ring_drive_out, d;
	logic [7:0] instr_out;
	int num_errors = 0;
	int cmp_count = 0;
	int oe_cnt = 0;
	// 200 ns test clock over a 25 ns system clock
	localparam int CLK_PER_TCK = 8;
	always #12.5 clk_in = ~clk_in;
	// system clocks with the serial output enabled, for the shift span check
	always @(posedge clk_in) begin
		if (tdo_oe_out === 1'b1) begin
			oe_cnt++;
		end
	end
	mjid_tap #(.MAKER_CODE(ID[11:1]), .DEVICE_CODE(ID[27:12]), .REVISION(ID[31:28])) mjid_tap_inst (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .tck_in(tck_in), .tms_in(tms_in),
		.tdi_in(tdi_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .ring_in(ring_in),
		.ring_drive_out(ring_drive_out), .test_drive_out(test_drive_out),
		.highz_out(highz_out), .instr_out(instr_out));
	mjid_ctl_model mjid_ctl_model_inst (.tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in),
		.tdo_in(tdo_out));
	task chk(input logic [112:0] seen, input logic [112:0] exp, input string m);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	task sync(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task load(input logic [7:0] op);
		mjid_ctl_model_inst.scan(1'b1, 8, 113'(op), d);
		sync(2);
		chk(d, 113'h01, "ir capture");
		chk(113'(instr_out), 113'(op), "instr");
		chk(113'({highz_out, test_drive_out}), 113'({op == 8'h03, op == 8'h00 || op == 8'h07}), "ctl");
	endtask
	task t_codes();
		logic [7:0] ops [6];
		ops = '{8'h00, 8'h05, 8'h21, 8'h07, 8'h03, 8'hff};
		for (int i = 0; i < 6; i++) begin
			load(ops[i]);
			mjid_ctl_model_inst.scan(1'b0, 2, 113'h1, d);
			chk(d, (i > 2) ? 113'h2 : (i == 2) ? 113'(ID[1:0]) : 113'(RING[1:0]), "dr path");
		end
	endtask
	task t_idcode();
		int oe_mark;
		load(8'h21);
		oe_mark = oe_cnt;
		mjid_ctl_model_inst.scan(1'b0, 32, 113'h0, d);
		chk(d, 113'(ID), "id word");
		chk(113'(oe_cnt - oe_mark), 113'(32 * CLK_PER_TCK), "oe span");
	endtask
	task t_bsr();
		load(8'h05);
		mjid_ctl_model_inst.scan(1'b0, 113, ~RING, d);
		chk(d, RING, "sample");
		sync(2);
		chk(ring_drive_out, ~RING, "preload");
		load(8'h00);
		ring_in = ~RING;
		mjid_ctl_model_inst.scan(1'b0, 113, RING, d);
		chk(d, ~RING, "extest");
		chk(ring_drive_out, RING, "drive");
	endtask
	task t_tlr();
		load(8'hff);
		mjid_ctl_model_inst.tlr();
		sync(4);
		chk(113'(instr_out), 113'h21, "tlr");
	endtask
	task end_of_test();
		$display("errors %0d checks %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		sync(10);
		rst_n_in = 1'b1;
		sync(4);
		chk(113'({instr_out, highz_out, test_drive_out}), 113'h84, "reset");
		// the port wakes in test-logic-reset; scans start from run-test-idle
		mjid_ctl_model_inst.tlr();
		t_codes();
		t_idcode();
		t_bsr();
		t_tlr();
		end_of_test();
	end
	// a stuck run takes far longer than the roughly 94 us of traffic
	initial begin
		#1000000;
		num_errors++;
		end_of_test();
	end
endmodule
bind mjid_tap mjid_tap_props mjid_tap_props_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .ring_drive_out(ring_drive_out),
	.test_drive_out(test_drive_out), .highz_out(highz_out), .instr_out(instr_out));
`default_nettype wire
